// File: swc_top.sv
// swc_top: sleep/wake sequencer with its wishbone register file
// assumes synchronous pins, one clock, host drives the sleep request pin
//
// Function
// - mode 0 keeps the device awake always
// - mode 1 sleeps or wakes by the sleep request pin level only
// - mode 4 alternates sleep period then wake period autonomously
// - mode 5 cycles while pin asserted, wakes at once when released
// - mode 7 stays awake permanently while supporting mode 8 peers
// - mode 8 sleeps for sleep period then wakes for wake period, repeating
// - synchronous modes refused when radio rate is zero; never mixed with async
// - option words with bits 0 and 1 both set are refused
// - option bit 0 forces coordinator role, bit 1 forbids it
// - bits 2..5 drive status messages, early wake, seniority, rapid sync
// - bit 8 forces full wake time; bit 10 enables randomized sampling
// - cycle count 1..65535 sets sleep periods between awake indications
// - quiet wakes check for data, wake fully if found, else sleep again
// - awake indicator asserts whenever awake or waking: every nth async cyclic wake, every sync wake, or a quiet wake that finds data
// - cycle count ignored in synchronous modes
// - sleep period in 10 ms units, zero means no sleep
// - wake period in 1 ms units, counted after data in async sleep
// - nonzero host delay holds output after wake; serial input ends it
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
module swc_top
    import swc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sleep_request_pin,
    input wire logic serial_data_seen,
    input wire logic radio_data_seen,
    output logic awake_indicator_pin,
    output logic radio_asleep,
    output logic host_output_hold,
    output logic sleep_coordinator,
    output logic sleep_status_msg_en,
    output logic early_wake_en,
    output logic equal_seniority,
    output logic rapid_sync_en,
    output logic random_sampling_en
);
    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        swc_cfg_t cfg;
        swc_bus_t bus;
        swc_out_t out;
        swc_state_t st;
        logic [17:0] tick_cnt;
        logic [21:0] sub_ms;
        logic [21:0] timer;
        logic [15:0] wake_cnt;
        logic [15:0] host_cnt;
    } swc_regs_t;

    swc_regs_t r;
    swc_regs_t next_r;

    ////////////////////////////////////////////////////////////////////////
    // sequencer helpers
    function automatic logic is_sync(input logic [3:0] m);
        return (m == MODE_SUPPORT) || (m == MODE_SYNC);
    endfunction

    function automatic logic mode_ok(input logic [3:0] m, input logic [7:0] rate);
        logic ok;
        ok = (m == MODE_NORMAL) || (m == MODE_PIN) || (m == MODE_CYCLIC) ||
             (m == MODE_PIN_CYCLIC) || (m == MODE_SUPPORT) || (m == MODE_SYNC);
        if (is_sync(m) && rate == 8'h00) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    function automatic logic [21:0] clamp(input logic [21:0] v, input logic [21:0] mx);
        return (v > mx) ? mx : v;
    endfunction

    function automatic swc_regs_t enter_sleep(input swc_regs_t v);
        swc_regs_t s;
        s = v;
        s.st = SWC_SLEEP;
        s.timer = v.cfg.sleep_len;
        s.sub_ms = 22'h0;
        return s;
    endfunction

    function automatic swc_regs_t enter_wake(input swc_regs_t v);
        swc_regs_t w;
        w = v;
        w.st = SWC_WAKE;
        w.wake_cnt = 16'h0;
        w.timer = v.cfg.wake_len;
        w.host_cnt = v.cfg.host_dly;
        return w;
    endfunction

    localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);
    localparam logic [21:0] UNIT_LAST = 22'(SLEEP_UNIT_MS - 1);

    logic wr;
    logic rd;
    logic ms_tick;
    logic cyclic;
    logic sync_mode;
    logic data_seen;
    logic [31:0] status_word;

    always_comb begin
        next_r = r;
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !r.bus.ack;
        rd = wb_cyc_i && wb_stb_i && !wb_we_i && !r.bus.ack;
        ms_tick = (r.tick_cnt == TICK_LAST);
        cyclic = (r.cfg.mode == MODE_CYCLIC) || (r.cfg.mode == MODE_SYNC) ||
                 (r.cfg.mode == MODE_PIN_CYCLIC && sleep_request_pin);
        sync_mode = is_sync(r.cfg.mode);
        data_seen = serial_data_seen || radio_data_seen;
        status_word = 32'h0;
        status_word[3:0] = r.st;
        status_word[4] = r.out.awake_ind;
        status_word[5] = r.out.host_hold;

        ////////////////////////////////////////////////////////////////////
        // wishbone slave, one wait state, unmapped reads as zero
        next_r.bus.ack = (wb_cyc_i && wb_stb_i) && !r.bus.ack;
        next_r.bus.dat = 32'h0;
        if (rd) begin
            unique case (wb_adr_i)
                ADR_MODE: next_r.bus.dat = {28'h0, r.cfg.mode};
                ADR_SLEEP: next_r.bus.dat = {10'h0, r.cfg.sleep_len};
                ADR_WAKE: next_r.bus.dat = {10'h0, r.cfg.wake_len};
                ADR_CYCLES: next_r.bus.dat = {16'h0, r.cfg.cycles};
                ADR_OPTIONS: next_r.bus.dat = {21'h0, r.cfg.options};
                ADR_RATE: next_r.bus.dat = {24'h0, r.cfg.rate};
                ADR_HOSTDLY: next_r.bus.dat = {16'h0, r.cfg.host_dly};
                ADR_STATUS: next_r.bus.dat = status_word;
                default: next_r.bus.dat = 32'h0;
            endcase
        end
        if (wr && wb_sel_i == 4'hf) begin
            unique case (wb_adr_i)
                ADR_MODE: begin
                    if (mode_ok(wb_dat_i[3:0], r.cfg.rate) && wb_dat_i[31:4] == 28'h0) begin
                        next_r.cfg.mode = wb_dat_i[3:0];
                    end
                end
                ADR_SLEEP: next_r.cfg.sleep_len = clamp(wb_dat_i[21:0], MAX_SLEEP);
                ADR_WAKE: begin
                    if (wb_dat_i[21:0] != 22'h0) begin
                        next_r.cfg.wake_len = clamp(wb_dat_i[21:0], MAX_WAKE);
                    end
                end
                ADR_CYCLES: begin
                    if (wb_dat_i[15:0] != 16'h0) begin
                        next_r.cfg.cycles = wb_dat_i[15:0];
                    end
                end
                ADR_OPTIONS: begin
                    if (!(wb_dat_i[OPT_COORD] && wb_dat_i[OPT_NOCOORD])) begin
                        next_r.cfg.options = wb_dat_i[10:0] & OPT_MASK;
                    end
                end
                ADR_RATE: begin
                    next_r.cfg.rate = wb_dat_i[7:0];
                    if (wb_dat_i[7:0] == 8'h0 && sync_mode) begin
                        next_r.cfg.mode = MODE_NORMAL;
                    end
                end
                ADR_HOSTDLY: next_r.cfg.host_dly = wb_dat_i[15:0];
                default: ;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // millisecond tick and timers
        next_r.tick_cnt = ms_tick ? 18'h0 : r.tick_cnt + 18'h1;
        if (ms_tick && r.st == SWC_SLEEP) begin
            next_r.sub_ms = (r.sub_ms == UNIT_LAST) ? 22'h0 : r.sub_ms + 22'h1;
            if (r.sub_ms == UNIT_LAST && r.timer != 22'h0) begin
                next_r.timer = r.timer - 22'h1;
            end
        end else if (ms_tick && r.timer != 22'h0) begin
            next_r.timer = r.timer - 22'h1;
        end
        if (r.host_cnt != 16'h0) begin
            if (serial_data_seen) begin
                next_r.host_cnt = 16'h0;
            end else if (ms_tick) begin
                next_r.host_cnt = r.host_cnt - 16'h1;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // sequencer
        unique case (r.st)
            SWC_AWAKE: begin
                next_r.out.awake_ind = 1'b1;
                if (r.cfg.mode == MODE_PIN && sleep_request_pin) begin
                    next_r.st = SWC_SLEEP;
                end else if (cyclic && r.cfg.sleep_len != 22'h0) begin
                    next_r = enter_sleep(next_r);
                end
            end
            SWC_SLEEP: begin
                next_r.out.awake_ind = 1'b0;
                if (r.cfg.mode == MODE_PIN) begin
                    if (!sleep_request_pin) begin
                        next_r.st = SWC_WAKE;
                        next_r.timer = 22'h0;
                        next_r.host_cnt = r.cfg.host_dly;
                    end
                end else if (!cyclic || r.cfg.sleep_len == 22'h0) begin
                    next_r.st = SWC_AWAKE;
                    next_r.wake_cnt = 16'h0;
                    next_r.host_cnt = r.cfg.host_dly;
                end else if (r.timer == 22'h0) begin
                    next_r.wake_cnt = r.wake_cnt + 16'h1;
                    if (sync_mode || r.wake_cnt + 16'h1 >= r.cfg.cycles) begin
                        next_r = enter_wake(next_r);
                    end else begin
                        next_r.st = SWC_CHECK;
                        next_r.timer = 22'h1;
                    end
                end
            end
            SWC_CHECK: begin
                if (data_seen) begin
                    next_r = enter_wake(next_r);
                end else if (r.timer == 22'h0) begin
                    next_r = enter_sleep(next_r);
                end
            end
            SWC_WAKE: begin
                next_r.out.awake_ind = 1'b1;
                if (data_seen && !sync_mode && !r.cfg.options[OPT_FULL_WAKE]) begin
                    next_r.timer = r.cfg.wake_len;
                end
                if (r.cfg.mode == MODE_PIN) begin
                    if (sleep_request_pin) begin
                        next_r.st = SWC_SLEEP;
                    end
                end else if (!cyclic || r.timer == 22'h0) begin
                    next_r.st = SWC_AWAKE;
                end
            end
            default: next_r.st = SWC_AWAKE;
        endcase
        if (r.cfg.mode == MODE_NORMAL || r.cfg.mode == MODE_SUPPORT) begin
            next_r.st = SWC_AWAKE;
        end
        if (next_r.cfg.mode != r.cfg.mode) begin
            next_r.st = SWC_AWAKE;
            next_r.timer = 22'h0;
            next_r.sub_ms = 22'h0;
            next_r.wake_cnt = 16'h0;
        end
        if (next_r.st == SWC_SLEEP) begin
            next_r.host_cnt = 16'h0;
        end
        if (serial_data_seen) begin
            next_r.host_cnt = 16'h0;
        end
        next_r.out.awake_ind = (next_r.st == SWC_AWAKE) || (next_r.st == SWC_WAKE);
        next_r.out.asleep = (next_r.st == SWC_SLEEP);
        next_r.out.host_hold = (next_r.host_cnt != 16'h0);

        ////////////////////////////////////////////////////////////////////
        // option decode, synchronous-only bits gated by the mode
        next_r.out.coordinator = sync_mode && r.cfg.options[OPT_COORD];
        next_r.out.status_msg = sync_mode && r.cfg.options[OPT_STATUS_MSG];
        next_r.out.early_wake = sync_mode && !r.cfg.options[OPT_NO_EARLY];
        next_r.out.equal_seniority = sync_mode && r.cfg.options[OPT_EQUAL];
        next_r.out.rapid_sync = sync_mode && !r.cfg.options[OPT_NO_RAPID];
        next_r.out.random_sample = r.cfg.options[OPT_RANDOM];
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.cfg.mode <= RST_MODE;
            r.cfg.sleep_len <= RST_SLEEP;
            r.cfg.wake_len <= RST_WAKE;
            r.cfg.cycles <= RST_CYCLES;
            r.cfg.options <= RST_OPTIONS;
            r.cfg.rate <= RST_RATE;
            r.cfg.host_dly <= RST_HOSTDLY;
            r.st <= SWC_AWAKE;
            r.out.awake_ind <= 1'b1;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign wb_dat_o = r.bus.dat;
    assign wb_ack_o = r.bus.ack;
    assign awake_indicator_pin = r.out.awake_ind;
    assign radio_asleep = r.out.asleep;
    assign host_output_hold = r.out.host_hold;
    assign sleep_coordinator = r.out.coordinator;
    assign sleep_status_msg_en = r.out.status_msg;
    assign early_wake_en = r.out.early_wake;
    assign equal_seniority = r.out.equal_seniority;
    assign rapid_sync_en = r.out.rapid_sync;
    assign random_sampling_en = r.out.random_sample;
endmodule

// File: swc_pkg.sv
// swc_pkg: constants, register map and carrier types for the sleep/wake controller
// assumes a 250 MHz core clock and a classic wishbone slave with 32-bit data
package swc_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_MHZ * TICK_US;
    localparam int unsigned SLEEP_UNIT_MS = 10;
    localparam logic [7:0] ADR_MODE = 8'h00;
    localparam logic [7:0] ADR_SLEEP = 8'h04;
    localparam logic [7:0] ADR_WAKE = 8'h08;
    localparam logic [7:0] ADR_CYCLES = 8'h0c;
    localparam logic [7:0] ADR_OPTIONS = 8'h10;
    localparam logic [7:0] ADR_RATE = 8'h14;
    localparam logic [7:0] ADR_HOSTDLY = 8'h18;
    localparam logic [7:0] ADR_STATUS = 8'h1c;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_PIN = 4'h1;
    localparam logic [3:0] MODE_CYCLIC = 4'h4;
    localparam logic [3:0] MODE_PIN_CYCLIC = 4'h5;
    localparam logic [3:0] MODE_SUPPORT = 4'h7;
    localparam logic [3:0] MODE_SYNC = 4'h8;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [21:0] RST_SLEEP = 22'h00012c;
    localparam logic [21:0] MAX_SLEEP = 22'h15f900;
    localparam logic [21:0] RST_WAKE = 22'h000d08;
    localparam logic [21:0] MAX_WAKE = 22'h36ee80;
    localparam logic [15:0] RST_CYCLES = 16'h0001;
    localparam logic [10:0] RST_OPTIONS = 11'h002;
    localparam logic [10:0] OPT_MASK = 11'h53f;
    localparam logic [7:0] RST_RATE = 8'h01;
    localparam logic [15:0] RST_HOSTDLY = 16'h0000;
    localparam int OPT_COORD = 0;
    localparam int OPT_NOCOORD = 1;
    localparam int OPT_STATUS_MSG = 2;
    localparam int OPT_NO_EARLY = 3;
    localparam int OPT_EQUAL = 4;
    localparam int OPT_NO_RAPID = 5;
    localparam int OPT_FULL_WAKE = 8;
    localparam int OPT_RANDOM = 10;

    typedef enum logic [3:0] {
        SWC_AWAKE = 4'b0001,
        SWC_SLEEP = 4'b0010,
        SWC_CHECK = 4'b0100,
        SWC_WAKE = 4'b1000
    } swc_state_t;

    typedef struct packed {
        logic [3:0] mode;
        logic [21:0] sleep_len;
        logic [21:0] wake_len;
        logic [15:0] cycles;
        logic [10:0] options;
        logic [7:0] rate;
        logic [15:0] host_dly;
    } swc_cfg_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } swc_bus_t;

    typedef struct packed {
        logic asleep;
        logic awake_ind;
        logic host_hold;
        logic coordinator;
        logic status_msg;
        logic early_wake;
        logic equal_seniority;
        logic rapid_sync;
        logic random_sample;
    } swc_out_t;
endpackage

// File: swc_checker.sv
// swc_checker: port-level assertions for the sleep/wake controller
// assumes only the ports of swc_top; attached by the bind at the foot
`timescale 1ns/1ns
module swc_checker
    import swc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic serial_data_seen,
    input wire logic awake_indicator_pin,
    input wire logic radio_asleep,
    input wire logic host_output_hold,
    input wire logic sleep_coordinator,
    input wire logic sleep_status_msg_en,
    input wire logic early_wake_en,
    input wire logic equal_seniority,
    input wire logic rapid_sync_en,
    input wire logic random_sampling_en
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    bus_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
        else $error("request not answered one cycle later");
    ack_single_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) && clk_en |=> !wb_ack_o)
        else $error("ack without request");
    sleep_dark_a: assert property (radio_asleep |-> !awake_indicator_pin)
        else $error("awake indicator high while asleep");
    hold_awake_a: assert property (host_output_hold |-> !radio_asleep)
        else $error("host hold while asleep");
    serial_stop_a: assert property (serial_data_seen && clk_en |=> !host_output_hold)
        else $error("serial input did not end host hold");
    freeze_a: assert property (!clk_en |=> $stable(radio_asleep) &&
        $stable(awake_indicator_pin) && $stable(wb_ack_o))
        else $error("state moved while clock enable low");
    role_write_a: assert property ($changed({sleep_coordinator, sleep_status_msg_en,
        early_wake_en, equal_seniority, rapid_sync_en, random_sampling_en})
        |-> (wb_ack_o && wb_we_i) || ($past(wb_ack_o) && $past(wb_we_i)))
        else $error("option outputs changed without a write");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind swc_top swc_checker chk (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .serial_data_seen(serial_data_seen), .awake_indicator_pin(awake_indicator_pin),
    .radio_asleep(radio_asleep), .host_output_hold(host_output_hold),
    .sleep_coordinator(sleep_coordinator), .sleep_status_msg_en(sleep_status_msg_en),
    .early_wake_en(early_wake_en), .equal_seniority(equal_seniority),
    .rapid_sync_en(rapid_sync_en), .random_sampling_en(random_sampling_en));

// File: swc_host.sv
// swc_host: behavioural host on the sleep pins
// assumes commands from the testbench; pins change just after the rising edge
`timescale 1ns/1ns
module swc_host
    import swc_pkg::*;
(
    input wire logic core_clk,
    input wire logic want_sleep,
    input wire logic poke_serial,
    input wire logic poke_radio,
    output logic sleep_request_pin = 1'b0,
    output logic serial_data_seen = 1'b0,
    output logic radio_data_seen = 1'b0
);
    always @(posedge core_clk) begin
        sleep_request_pin <= want_sleep;
        serial_data_seen <= poke_serial;
        radio_data_seen <= poke_radio;
    end
endmodule

// File: testbench.sv
// testbench: register and pin sequences for the sleep/wake controller
// assumes swc_top, swc_host and the bound checker
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench
    import swc_pkg::*;
;
    logic core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, hs = 1'b0, ss = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic wb_ack_o, slp, ser, rad, ind, asl, hold, crd, stm, ewk, eql, rps, rnd;
    logic [31:0] rst_tab [8] = '{32'h0, 32'h12c, 32'hd08, 32'h1, 32'h2, 32'h1, 32'h0, 32'h11};
    logic [31:0] bad_tab [5] = '{32'h2, 32'h3, 32'h6, 32'h9, 32'hf};
    int n_fail = 0, n_tests = 0, cyc_cnt = 0;
    always #2 core_clk = ~core_clk;
    swc_host host (.core_clk(core_clk), .want_sleep(hs), .poke_serial(ss), .poke_radio(1'b0),
        .sleep_request_pin(slp), .serial_data_seen(ser), .radio_data_seen(rad));
    swc_top dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sleep_request_pin(slp), .serial_data_seen(ser), .radio_data_seen(rad),
        .awake_indicator_pin(ind), .radio_asleep(asl), .host_output_hold(hold),
        .sleep_coordinator(crd), .sleep_status_msg_en(stm), .early_wake_en(ewk),
        .equal_seniority(eql), .rapid_sync_en(rps), .random_sampling_en(rnd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'hf);
        `CHK("register", e, rdat)
    endtask
    task automatic wlvl(input logic e);
        int n;
        n = 0;
        while (asl !== e && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        `CHK("asleep", e, asl)
    endtask
    task test_done;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_fail++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 8; i++) rd(8'(4 * i), rst_tab[i]);
        rd(8'h20, 32'h0);
        wr(ADR_MODE, 32'h4);
        wlvl(1'b1);
        for (int i = 0; i < 5; i++) begin
            wr(ADR_MODE, bad_tab[i]);
            rd(ADR_MODE, 32'h4);
        end
        wr(ADR_MODE, 32'h0);
        hs <= 1'b1;
        repeat (6) @(posedge core_clk);
        `CHK("normal awake", 1'b0, asl)
        wr(ADR_MODE, 32'h1);
        wlvl(1'b1);
        clk_en <= 1'b0;
        hs <= 1'b0;
        repeat (5) @(posedge core_clk);
        `CHK("frozen", 1'b1, asl)
        clk_en <= 1'b1;
        wlvl(1'b0);
        wr(ADR_HOSTDLY, 32'h5);
        hs <= 1'b1;
        wlvl(1'b1);
        hs <= 1'b0;
        wlvl(1'b0);
        repeat (3) @(posedge core_clk);
        `CHK("host hold", 1'b1, hold)
        ss <= 1'b1;
        @(posedge core_clk);
        ss <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK("host hold", 1'b0, hold)
        rd(ADR_HOSTDLY, 32'h5);
        wr(ADR_MODE, 32'h5);
        hs <= 1'b1;
        repeat (4) @(posedge core_clk);
        `CHK("pin cycle", 1'b1, asl)
        hs <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK("pin wake", 2'b01, {asl, ind})
        wr(ADR_RATE, 32'h0);
        wr(ADR_MODE, 32'h8);
        rd(ADR_MODE, 32'h5);
        wr(ADR_RATE, 32'h1);
        wr(ADR_MODE, 32'h7);
        rd(ADR_MODE, 32'h7);
        hs <= 1'b1;
        repeat (6) @(posedge core_clk);
        `CHK("support awake", 1'b0, asl)
        wr(ADR_OPTIONS, 32'h3);
        rd(ADR_OPTIONS, 32'h2);
        wr(ADR_OPTIONS, 32'h1);
        @(posedge core_clk);
        `CHK("options", 6'b101010, {crd, stm, ewk, eql, rps, rnd})
        wr(ADR_OPTIONS, 32'h43c);
        @(posedge core_clk);
        `CHK("options", 6'b010101, {crd, stm, ewk, eql, rps, rnd})
        wr(ADR_MODE, 32'h8);
        rd(ADR_MODE, 32'h8);
        `CHK("sync sleep", 1'b1, asl)
        wr(ADR_RATE, 32'h0);
        rd(ADR_MODE, 32'h0);
        `CHK("async roles", 5'b0, {crd, stm, ewk, eql, rps})
        wr(ADR_CYCLES, 32'h0);
        rd(ADR_CYCLES, 32'h1);
        wr(ADR_CYCLES, 32'h3);
        xfer(1'b1, ADR_CYCLES, 32'h5, 4'h1);
        rd(ADR_CYCLES, 32'h3);
        wr(ADR_SLEEP, 32'h15f901);
        rd(ADR_SLEEP, 32'h15f900);
        wr(ADR_SLEEP, 32'h0);
        rd(ADR_SLEEP, 32'h0);
        wr(ADR_WAKE, 32'h0);
        rd(ADR_WAKE, 32'hd08);
        wr(ADR_WAKE, 32'h36ee81);
        rd(ADR_WAKE, 32'h36ee80);
        test_done();
    end
endmodule
